//--- src/ldc_pkg.sv
// Constants and types shared by both ends of the LED driver link.
// Assumes nothing beyond a SystemVerilog compiler.
package ldc_pkg;

  // ==========================================================
  // Channel layout
  localparam int NUM_CH = 16;
  localparam int TRIM_W = 6;
  localparam int BRIGHT_W = 12;
  localparam int TRIM_LEN = NUM_CH * TRIM_W;
  localparam int BRIGHT_LEN = NUM_CH * BRIGHT_W;
  localparam logic [5:0] TRIM_FULL_SCALE = 6'h3F;
  localparam logic [11:0] COUNT_END = 12'hFFF;

  // ==========================================================
  // Controller register map
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_TXDATA = 8'h08;
  localparam logic [7:0] OFS_RXDATA = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam int CTRL_BLANK_BIT = 0;
  localparam int CTRL_MODE_BIT = 1;
  localparam logic CTRL_BLANK_RESET = 1'b1;
  localparam logic CTRL_MODE_RESET = 1'b0;
  localparam int CMD_NBITS_LSB = 0;
  localparam int CMD_NBITS_W = 6;
  localparam int CMD_LATCH_BIT = 8;
  localparam logic [5:0] CMD_MAX_BITS = 6'h20;
  localparam int STATUS_BUSY_BIT = 0;

  // ==========================================================
  // Timing, in ref_clk cycles
  localparam int SCLK_HALF_DEF = 4;
  localparam int PWM_HALF_DEF = 4;
  localparam int LATCH_HOLD_DEF = 32;

  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_SHIFT_LOW,
    SEQ_SHIFT_HIGH,
    SEQ_LATCH_HIGH,
    SEQ_LATCH_LOW
  } ldc_seq_state_t;

endpackage

//--- src/ldc_link_if.sv
// Pins between the LED driver and its controller.
// Assumes the controller end drives every pin except the serial output.
`timescale 1ns/1ns
interface ldc_link_if;
  logic link_rst_n;
  logic serial_clock;
  logic serial_data_in;
  logic serial_data_out;
  logic latch_strobe;
  logic mode_trim;
  logic blank;
  logic pwm_reference_clock;

  modport dev (
    input link_rst_n,
    input serial_clock,
    input serial_data_in,
    output serial_data_out,
    input latch_strobe,
    input mode_trim,
    input blank,
    input pwm_reference_clock
  );

  modport ctrl (
    output link_rst_n,
    output serial_clock,
    output serial_data_in,
    input serial_data_out,
    output latch_strobe,
    output mode_trim,
    output blank,
    output pwm_reference_clock
  );
endinterface

//--- src/ldc_device.sv
// LED driver end: serial chain, trim and brightness latches, PWM.
// Assumes the controller makes both clocks and keeps the chain quiet
// while the latch strobe is high.
// Both latches clear on the link reset, but software still loads both
// before it lifts blank.
`timescale 1ns/1ns
module ldc_device (
  ldc_link_if.dev link,
  output logic [ldc_pkg::NUM_CH-1:0] sink_output_channel,
  output logic [ldc_pkg::TRIM_LEN-1:0] channel_current_level
);
  import ldc_pkg::*;

  logic [BRIGHT_LEN-1:0] shift_reg;
  logic strobe_meta_reg;
  logic strobe_sync_reg;
  logic strobe_prev_reg;
  logic mode_meta_reg;
  logic mode_reg;
  logic latch_pulse;
  logic [TRIM_LEN-1:0] current_trim_reg;
  logic [BRIGHT_LEN-1:0] brightness_code_reg;
  logic blank_clear;
  logic [11:0] count_reg;
  logic ended_reg;
  logic rst_meta_reg;
  logic pwm_rst_n_reg;

  // ==========================================================
  // Channel field pick, channel 15 sits at the top of each latch
  function automatic logic [11:0] channel_brightness_value(
    input logic [BRIGHT_LEN-1:0] vec,
    input int ch
  );
    channel_brightness_value = vec[ch*BRIGHT_W +: BRIGHT_W];
  endfunction

  function automatic logic [5:0] channel_trim_value(
    input logic [TRIM_LEN-1:0] vec,
    input int ch
  );
    channel_trim_value = vec[ch*TRIM_W +: TRIM_W];
  endfunction

  // ==========================================================
  // Serial chain, on the link's serial clock
  // One 192-bit chain; in trim mode only the low 96 bits matter.
  // Cleared at reset so the tap shows no unknown before a load.
  always_ff @(posedge link.serial_clock or negedge link.link_rst_n) begin
    if (!link.link_rst_n) begin
      shift_reg <= '0;
    end else begin
      shift_reg <= {shift_reg[BRIGHT_LEN-2:0], link.serial_data_in};
    end
  end

  // Chain tap follows the mode: bit 95 for trim, bit 191 otherwise
  always_comb begin
    if (mode_reg) begin
      link.serial_data_out = shift_reg[TRIM_LEN-1];
    end else begin
      link.serial_data_out = shift_reg[BRIGHT_LEN-1];
    end
  end

  // ==========================================================
  // Link reset release into the reference clock domain
  // Reset still drops at once; its release is retimed so that no flop
  // here sees reset lift beside a reference clock edge. The counter
  // keeps the raw reset, since blank holds it cleared at that time.
  always_ff @(posedge link.pwm_reference_clock
              or negedge link.link_rst_n) begin
    if (!link.link_rst_n) begin
      rst_meta_reg <= 1'b0;
      pwm_rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      pwm_rst_n_reg <= rst_meta_reg;
    end
  end

  // ==========================================================
  // Strobe and mode into the reference clock domain
  // The reference clock runs free, so the strobe edge is always seen.
  always_ff @(posedge link.pwm_reference_clock
              or negedge pwm_rst_n_reg) begin
    if (!pwm_rst_n_reg) begin
      strobe_meta_reg <= 1'b0;
      strobe_sync_reg <= 1'b0;
      strobe_prev_reg <= 1'b0;
    end else begin
      strobe_meta_reg <= link.latch_strobe;
      strobe_sync_reg <= strobe_meta_reg;
      strobe_prev_reg <= strobe_sync_reg;
    end
  end

  // Mode only moves while the strobe is low, so equal latency is safe
  always_ff @(posedge link.pwm_reference_clock
              or negedge pwm_rst_n_reg) begin
    if (!pwm_rst_n_reg) begin
      mode_meta_reg <= 1'b0;
      mode_reg <= 1'b0;
    end else begin
      mode_meta_reg <= link.mode_trim;
      mode_reg <= mode_meta_reg;
    end
  end

  assign latch_pulse = strobe_sync_reg & ~strobe_prev_reg;

  // ==========================================================
  // Latches
  // The chain is idle while the strobe is high, so its word is
  // stable when the synchronised edge arrives here.
  always_ff @(posedge link.pwm_reference_clock
              or negedge pwm_rst_n_reg) begin
    if (!pwm_rst_n_reg) begin
      current_trim_reg <= '0;
    end else if (latch_pulse && mode_reg) begin
      current_trim_reg <= shift_reg[TRIM_LEN-1:0];
    end
  end

  // No blanking needed: a mid-cycle load acts on the next compare
  always_ff @(posedge link.pwm_reference_clock
              or negedge pwm_rst_n_reg) begin
    if (!pwm_rst_n_reg) begin
      brightness_code_reg <= '0;
    end else if (latch_pulse && !mode_reg) begin
      brightness_code_reg <= shift_reg;
    end
  end

  // ==========================================================
  // Brightness counter
  // Blank acts as an asynchronous clear so the reset is immediate.
  // Limitation: blank release is not retimed, so a release right at a
  // reference edge may or may not count that edge.
  assign blank_clear = link.blank | ~link.link_rst_n;

  always_ff @(posedge link.pwm_reference_clock or posedge blank_clear) begin
    if (blank_clear) begin
      count_reg <= '0;
    end else if (count_reg != COUNT_END) begin
      count_reg <= count_reg + 12'h001;
    end
  end

  // One edge past FFF the cycle is over; only blank or the link reset restarts it
  always_ff @(posedge link.pwm_reference_clock or posedge blank_clear) begin
    if (blank_clear) begin
      ended_reg <= 1'b0;
    end else if (count_reg == COUNT_END) begin
      ended_reg <= 1'b1;
    end
  end

  // ==========================================================
  // Sinks
  // Count k after the k-th edge; a channel of value v is lit for
  // counts 1..v, that is for v reference periods.
  // Blank gates each sink directly, so sinks drop without a clock.
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_sink
    logic [11:0] level;
    logic lit;

    assign level = channel_brightness_value(brightness_code_reg, ch);

    always_comb begin
      lit = 1'b0;
      if (!link.blank && !ended_reg && count_reg != 12'h000) begin
        lit = (count_reg <= level);
      end
      sink_output_channel[ch] = lit;
    end

    // Level in steps of full scale / TRIM_FULL_SCALE, zero when dark
    always_comb begin
      if (lit) begin
        channel_current_level[ch*TRIM_W +: TRIM_W] =
          channel_trim_value(current_trim_reg, ch);
      end else begin
        channel_current_level[ch*TRIM_W +: TRIM_W] = '0;
      end
    end
  end

endmodule

//--- src/ldc_ctrl.sv
// Controller end: APB slave registers, serial sequencer, clock dividers.
// Assumes an APB master on ref_clk; the device sits on the link.
`timescale 1ns/1ns
module ldc_ctrl #(
  parameter int SCLK_HALF = ldc_pkg::SCLK_HALF_DEF,
  parameter int PWM_HALF = ldc_pkg::PWM_HALF_DEF,
  parameter int LATCH_HOLD = ldc_pkg::LATCH_HOLD_DEF
) (
  input logic ref_clk,
  input logic rst_n,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  ldc_link_if.ctrl link
);
  import ldc_pkg::*;

  ldc_seq_state_t state_reg;
  logic blank_reg;
  logic mode_reg;
  logic [31:0] tx_reg;
  logic [31:0] rx_reg;
  logic [5:0] nbits_reg;
  logic latch_req_reg;
  logic [5:0] bits_left_reg;
  logic [15:0] div_reg;
  logic [15:0] pwm_div_reg;
  logic pwm_clk_reg;
  logic sclk_reg;
  logic sdi_reg;
  logic strobe_reg;
  logic link_rst_reg;
  logic serial_data_out_meta_reg;
  logic serial_data_out_sync_reg;
  logic access;
  logic wr;
  logic busy;
  logic mapped;
  logic start;
  logic [5:0] cmd_nbits;

  // ==========================================================
  // APB decode; every access completes in its first access cycle
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign busy = (state_reg != SEQ_IDLE);
  assign pready = 1'b1;
  assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_CMD) ||
                  (paddr == OFS_TXDATA) || (paddr == OFS_RXDATA) ||
                  (paddr == OFS_STATUS);
  assign pslverr = access & ~mapped;
  assign start = wr && paddr == OFS_CMD && !busy;
  assign cmd_nbits = (pwdata[CMD_NBITS_LSB +: CMD_NBITS_W] > CMD_MAX_BITS) ?
                     CMD_MAX_BITS : pwdata[CMD_NBITS_LSB +: CMD_NBITS_W];

  always_comb begin
    prdata = '0;
    if (access && !pwrite) begin
      unique case (paddr)
        OFS_CTRL: begin
          prdata[CTRL_BLANK_BIT] = blank_reg;
          prdata[CTRL_MODE_BIT] = mode_reg;
        end
        OFS_CMD: begin
          prdata[CMD_NBITS_LSB +: CMD_NBITS_W] = nbits_reg;
          prdata[CMD_LATCH_BIT] = latch_req_reg;
        end
        OFS_TXDATA: prdata = tx_reg;
        OFS_RXDATA: prdata = rx_reg;
        OFS_STATUS: prdata[STATUS_BUSY_BIT] = busy;
        default: prdata = '0;
      endcase
    end
  end

  // Blank starts high so nothing lights on stale latches
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      blank_reg <= CTRL_BLANK_RESET;
      mode_reg <= CTRL_MODE_RESET;
    end else if (wr && paddr == OFS_CTRL) begin
      blank_reg <= pwdata[CTRL_BLANK_BIT];
      if (!busy) begin
        mode_reg <= pwdata[CTRL_MODE_BIT];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_reg <= '0;
    end else if (wr && paddr == OFS_TXDATA) begin
      tx_reg <= pwdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      nbits_reg <= '0;
      latch_req_reg <= 1'b0;
    end else if (start) begin
      nbits_reg <= cmd_nbits;
      latch_req_reg <= pwdata[CMD_LATCH_BIT];
    end
  end

  // ==========================================================
  // Link reset and free-running reference clock
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_rst_reg <= 1'b0;
    end else begin
      link_rst_reg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_div_reg <= '0;
      pwm_clk_reg <= 1'b0;
    end else if (pwm_div_reg == 16'(PWM_HALF - 1)) begin
      pwm_div_reg <= '0;
      pwm_clk_reg <= ~pwm_clk_reg;
    end else begin
      pwm_div_reg <= pwm_div_reg + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_data_out_meta_reg <= 1'b0;
      serial_data_out_sync_reg <= 1'b0;
    end else begin
      serial_data_out_meta_reg <= link.serial_data_out;
      serial_data_out_sync_reg <= serial_data_out_meta_reg;
    end
  end

  // ==========================================================
  // Serial sequencer: shift MSB first, then optional strobe pulse
  // After a shift the strobe rises on the same ref_clk edge that drives the serial clock low; with no bits it rises on the command write.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= SEQ_IDLE;
      div_reg <= '0;
      bits_left_reg <= '0;
      sclk_reg <= 1'b0;
      sdi_reg <= 1'b0;
      strobe_reg <= 1'b0;
      rx_reg <= '0;
    end else begin
      unique case (state_reg)
        SEQ_IDLE: begin
          div_reg <= '0;
          if (start) begin
            bits_left_reg <= cmd_nbits;
            if (cmd_nbits != 6'h00) begin
              sdi_reg <= tx_reg[5'(cmd_nbits - 6'h01)];
              state_reg <= SEQ_SHIFT_LOW;
            end else if (pwdata[CMD_LATCH_BIT]) begin
              strobe_reg <= 1'b1;
              state_reg <= SEQ_LATCH_HIGH;
            end
          end
        end
        SEQ_SHIFT_LOW: begin
          if (div_reg == 16'(SCLK_HALF - 1)) begin
            div_reg <= '0;
            sclk_reg <= 1'b1;
            rx_reg <= {rx_reg[30:0], serial_data_out_sync_reg};
            bits_left_reg <= bits_left_reg - 6'h01;
            state_reg <= SEQ_SHIFT_HIGH;
          end else begin
            div_reg <= div_reg + 16'h0001;
          end
        end
        SEQ_SHIFT_HIGH: begin
          if (div_reg == 16'(SCLK_HALF - 1)) begin
            div_reg <= '0;
            sclk_reg <= 1'b0;
            if (bits_left_reg != 6'h00) begin
              sdi_reg <= tx_reg[5'(bits_left_reg - 6'h01)];
              state_reg <= SEQ_SHIFT_LOW;
            end else if (latch_req_reg) begin
              strobe_reg <= 1'b1;
              state_reg <= SEQ_LATCH_HIGH;
            end else begin
              state_reg <= SEQ_IDLE;
            end
          end else begin
            div_reg <= div_reg + 16'h0001;
          end
        end
        SEQ_LATCH_HIGH: begin
          if (div_reg == 16'(LATCH_HOLD - 1)) begin
            div_reg <= '0;
            strobe_reg <= 1'b0;
            state_reg <= SEQ_LATCH_LOW;
          end else begin
            div_reg <= div_reg + 16'h0001;
          end
        end
        SEQ_LATCH_LOW: begin
          if (div_reg == 16'(LATCH_HOLD - 1)) begin
            div_reg <= '0;
            state_reg <= SEQ_IDLE;
          end else begin
            div_reg <= div_reg + 16'h0001;
          end
        end
      endcase
    end
  end

  assign link.link_rst_n = link_rst_reg;
  assign link.serial_clock = sclk_reg;
  assign link.serial_data_in = sdi_reg;
  assign link.latch_strobe = strobe_reg;
  assign link.mode_trim = mode_reg;
  assign link.blank = blank_reg;
  assign link.pwm_reference_clock = pwm_clk_reg;

endmodule

//--- dv/ldc_link_sva.sv
// Checker on the link pins between controller and driver.
// Assumes the controller drives the link from ref_clk flops.
`timescale 1ns/1ns
module ldc_link_sva #(
  parameter int LATCH_HOLD = 32
) (
  input logic ref_clk,
  input logic rst_n,
  input logic link_rst_n,
  input logic serial_clock,
  input logic serial_data_in,
  input logic serial_data_out,
  input logic latch_strobe,
  input logic mode_trim,
  input logic blank,
  input logic pwm_reference_clock
);
  int strobe_cnt;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Length of the current strobe pulse
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_cnt <= 0;
    end else begin
      strobe_cnt <= latch_strobe ? strobe_cnt + 1 : 0;
    end
  end

  // ==========================================================
  // Link assertions
  a_mode_strobe_low: assert property (
    $changed(mode_trim) |-> !latch_strobe && !$past(latch_strobe))
    else $error("mode changed with strobe high");
  a_blank_at_start: assert property (
    $rose(link_rst_n) |-> blank)
    else $error("outputs enabled at start");
  a_data_stable: assert property (
    $rose(serial_clock) |-> $stable(serial_data_in))
    else $error("serial data moved at clock rise");
  a_strobe_chain_quiet: assert property (
    latch_strobe |-> !serial_clock)
    else $error("shift during strobe");
  a_strobe_width: assert property (
    $fell(latch_strobe) |-> strobe_cnt == LATCH_HOLD)
    else $error("strobe width wrong");
  a_sclk_high_time: assert property (
    $rose(serial_clock) |-> serial_clock[*4] ##1 !serial_clock)
    else $error("serial clock high time wrong");
  a_sclk_low_time: assert property (
    $fell(serial_clock) |-> !serial_clock[*4])
    else $error("serial clock low time short");
  a_pwm_clk_half: assert property (
    $rose(pwm_reference_clock) |->
      pwm_reference_clock[*4] ##1 !pwm_reference_clock)
    else $error("reference clock half period wrong");

  c_trim_latch: cover property ($rose(latch_strobe) && mode_trim);
  c_bright_latch: cover property ($rose(latch_strobe) && !mode_trim);
  c_blank_release: cover property ($fell(blank));
  c_chain_out: cover property ($rose(serial_data_out));
endmodule

//--- dv/test_led_dot_correct_grayscale_pwm.sv
// Bench: controller and driver joined by the link, APB driven here.
// Assumes default divider and strobe hold of the controller.
`timescale 1ns/1ns
module test_led_dot_correct_grayscale_pwm;
  import ldc_pkg::*;
  typedef struct {logic [11:0] b; logic [5:0] t;} ldc_row_t;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic se;
  logic [31:0] rd;
  logic [NUM_CH-1:0] sink;
  logic [TRIM_LEN-1:0] lvl;
  logic [TRIM_LEN-1:0] trim_v;
  logic [BRIGHT_LEN-1:0] bright_v;
  int err_total = 0;
  int total_checks = 0;
  // Brightness and trim per channel, channel 0 first
  ldc_row_t rows [16] = '{'{12'h000, 6'h3F}, '{12'h001, 6'h01},
    '{12'h002, 6'h3E}, '{12'h003, 6'h15}, '{12'h004, 6'h2A},
    '{12'h005, 6'h00}, '{12'h006, 6'h20}, '{12'h007, 6'h1F},
    '{12'h008, 6'h3F}, '{12'h009, 6'h11}, '{12'h00A, 6'h22},
    '{12'h00F, 6'h33}, '{12'h01F, 6'h04}, '{12'h03F, 6'h08},
    '{12'hFFE, 6'h10}, '{12'hFFF, 6'h3F}};

  ldc_link_if link();
  ldc_ctrl ldc_ctrl_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  ldc_device ldc_device_inst (.link(link),
    .sink_output_channel(sink), .channel_current_level(lvl));
  ldc_link_sva ldc_link_sva_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .link_rst_n(link.link_rst_n), .serial_clock(link.serial_clock),
    .serial_data_in(link.serial_data_in),
    .serial_data_out(link.serial_data_out),
    .latch_strobe(link.latch_strobe), .mode_trim(link.mode_trim),
    .blank(link.blank),
    .pwm_reference_clock(link.pwm_reference_clock));

  always #4 ref_clk = ~ref_clk;

  // ==========================================================
  // Bus and compare tasks
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task note(input bit ok, input string m);
    total_checks++;
    if (!ok) begin
      err_total++;
      $display("[ERR] %0t %s mismatch", $time, m);
    end
  endtask
  task chk_word(input logic [31:0] g, input logic [31:0] e);
    note(g === e, "word");
  endtask
  task chk_sink(input logic [NUM_CH-1:0] g, input logic [NUM_CH-1:0] e);
    note(g === e, "sink");
  endtask
  task chk_lvl(input logic [TRIM_LEN-1:0] g, input logic [TRIM_LEN-1:0] e);
    note(g === e, "level");
  endtask

  // Whole words MSB first; busy polled, never a fixed wait
  task send(input logic [BRIGHT_LEN-1:0] v, input int n, input bit lat);
    for (int w = 0; w < n; w++) begin
      apb(1'b1, OFS_TXDATA, v[32*(n-1-w) +: 32]);
      apb(1'b1, OFS_CMD, {23'h0, lat && w == n - 1, 8'h20});
      rd = 32'h1;
      while (rd[0] !== 1'b0) apb(1'b0, OFS_STATUS, 32'h0);
    end
  endtask

  // Release blank mid-high of the reference clock, then count edges
  task pwm_pass(input int n);
    logic [NUM_CH-1:0] es;
    logic [TRIM_LEN-1:0] el;
    @(posedge link.pwm_reference_clock);
    apb(1'b1, OFS_CTRL, 32'h0);
    @(negedge link.pwm_reference_clock);
    chk_sink(sink, '0);
    for (int k = 1; k <= n; k++) begin
      @(negedge link.pwm_reference_clock);
      for (int c = 0; c < NUM_CH; c++) begin
        es[c] = k <= int'(rows[c].b);
        el[6*c +: 6] = es[c] ? rows[c].t : 6'h00;
      end
      chk_sink(sink, es);
      chk_lvl(lvl, el);
    end
  endtask

  task finish_test;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Whole run is about 38500 cycles
  initial begin
    repeat (100000) @(posedge ref_clk);
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test;
  end

  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (40) @(posedge ref_clk);
    chk_sink(sink, '0);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk_word(rd, 32'h1);
    apb(1'b0, 8'h14, 32'h0);
    chk_word({rd[30:0], se}, 32'h1);
    $display("reset test done");
    for (int c = 0; c < NUM_CH; c++) begin
      trim_v[6*c +: 6] = rows[c].t;
      bright_v[12*c +: 12] = rows[c].b;
    end
    apb(1'b1, OFS_CTRL, 32'h3);
    send({96'h0, trim_v}, 3, 1'b1);
    send('0, 1, 1'b0);
    apb(1'b0, OFS_RXDATA, 32'h0);
    chk_word(rd, trim_v[95:64]);
    apb(1'b1, OFS_CTRL, 32'h1);
    send(bright_v, 6, 1'b1);
    chk_lvl(lvl, '0);
    send('0, 1, 1'b0);
    apb(1'b0, OFS_RXDATA, 32'h0);
    chk_word(rd, bright_v[191:160]);
    $display("chain test done");
    // Past the top count so the stop at the end shows
    pwm_pass(4097);
    $display("full cycle test done");
    apb(1'b1, OFS_CTRL, 32'h1);
    @(negedge ref_clk);
    chk_sink(sink, '0);
    pwm_pass(3);
    $display("restart test done");
    apb(1'b1, OFS_CTRL, 32'h2);
    send({96'h0, {NUM_CH{6'h2A}}}, 3, 1'b1);
    @(negedge ref_clk);
    chk_lvl(lvl, {6'h2A, 6'h2A, 84'h0});
    apb(1'b1, OFS_CTRL, 32'h0);
    send({NUM_CH{12'hF00}}, 6, 1'b1);
    @(negedge ref_clk);
    chk_sink(sink, '1);
    chk_lvl(lvl, {NUM_CH{6'h2A}});
    $display("live load test done");
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk_sink(sink, '0);
    chk_lvl(lvl, '0);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk_word(rd, 32'h1);
    $display("mid-run reset test done");
    finish_test;
  end
endmodule
